/* core/sbi_top.sv */
// bootstrap latch, default configuration and switching start control
// assumes an AHB-Lite master; straps stable around reset release
// Operation
// RULE1 - all-high straps unmanaged; serial lite modes
// RULE2 - all-low straps 16-bit, lowest-high 8-bit
// RULE3 - latch serial id, answer matching id only
// RULE4 - eeprom load only when unmanaged, strap low
// RULE5 - debounce strobe when strap high
// RULE6 - module detect uses tx-enable straps
// RULE7 - unmanaged switches right after reset; code first waits for the BIST_CYC (256-cycle) power-up self test
// RULE8 - managed waits for init-complete bit
// RULE9 - host waits 100us to 1ms first
// RULE10 - never learn zero mac, drop reserved
// RULE11 - managed forwards reserved group to cpu
// RULE12 - default age time 300 seconds
// RULE13 - flow control at 96, no red/flood
// RULE14 - buffer pools 96/48 and 384/192
// RULE15 - frames 64..1522, pad, strict priority
// RULE16 - cpu port 100M full, 8-byte pad
// RULE17 - retry collisions, 16 attempts total
// RULE18 - phy addresses 08, 09, 10
// RULE19 - other phy addresses polled by host
// RULE20 - seven-wire mode uses bit 0 only
// RULE21 - uplink 1G full duplex only
// RULE22 - control frames only in managed mode
// RULE23 - memory self test at power-up, on request
// RULE24 - flag state machine stuck over 5s
// RULE25 - latch straps once at reset release
`timescale 1ns/1ps
module sbi_top #(
	parameter int TABLE_INIT_CYCLES = sbi_pkg::TABLE_INIT_CYC,
	parameter longint STUCK_CYCLES = sbi_pkg::STUCK_CYC
) (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic [15:0] strap_inputs_in,
	input wire logic [3:0] port_tx_enable_strap_in,
	input wire logic [2:0] serial_dev_id_in,
	input wire logic serial_id_valid_in,
	input wire logic [2:0] fsm_busy_in,
	input wire logic [47:0] frame_da_in,
	input wire logic [47:0] frame_sa_in,
	input wire logic frame_valid_in,
	input wire logic ctrl_frame_in,
	input wire logic [10:0] frame_len_in,
	input wire logic [1:0] uplink_speed_in,
	input wire logic uplink_full_duplex_in,
	input wire logic collision_in,
	input wire sbi_pkg::sbi_ahb_req_t ahb_req_in,
	input wire logic hready_in,
	input wire logic [31:0] hwdata_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	output sbi_pkg::sbi_cfg_t cfg_out,
	output sbi_pkg::sbi_mode_t mode_out,
	output logic serial_select_out,
	output logic switch_enable_out,
	output logic bist_busy_out,
	output logic stuck_flag_out,
	output logic frame_drop_out,
	output logic frame_to_cpu_out,
	output logic learn_ok_out,
	output logic retry_out,
	output logic tx_give_up_out,
	output logic uplink_mode_err_out
);
	import sbi_pkg::*;

	// ----------------------------------------
	// strap capture
	// ----------------------------------------
	logic straps_taken;
	logic [15:0] strap;
	logic [3:0] mod_type;
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			straps_taken <= 1'b0;
			strap <= STRAP_RESET;
			mod_type <= 4'h0;
		end else if (!straps_taken) begin
			straps_taken <= 1'b1; // first edge after release only [RULE25]
			strap <= strap_inputs_in;
			mod_type <= port_tx_enable_strap_in;
		end
	end

	function automatic sbi_mode_t decode_mode(input logic [2:0] s);
		case (s)
			3'b111: decode_mode = SBI_SER_UNMGD; // [RULE1]
			3'b011: decode_mode = SBI_SER_LITE; // [RULE1]
			3'b010: decode_mode = SBI_SER_MII; // [RULE1]
			3'b000: decode_mode = SBI_PAR16; // [RULE2]
			3'b001: decode_mode = SBI_PAR8; // [RULE2]
			default: decode_mode = SBI_BAD;
		endcase
	endfunction

	sbi_mode_t mode;
	logic serial_mode;
	logic unmanaged;
	assign mode = decode_mode(strap[3:1]);
	assign serial_mode = (mode == SBI_SER_UNMGD) || (mode == SBI_SER_LITE) ||
		(mode == SBI_SER_MII);
	assign unmanaged = (mode == SBI_SER_UNMGD);

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cfg_out <= '0;
			mode_out <= SBI_SER_UNMGD;
		end else begin
			mode_out <= mode;
			cfg_out.dev_id <= strap[6:4]; // [RULE3]
			cfg_out.debounce_en <= strap[STRAP_DEBOUNCE]; // [RULE5]
			cfg_out.eeprom_load_en <= unmanaged && !strap[STRAP_EEPROM]; // [RULE4]
			cfg_out.module_detect_en <= strap[STRAP_MODDET]; // [RULE6]
			cfg_out.timeout_mon_en <= strap[STRAP_TIMEOUT];
			cfg_out.managed <= !unmanaged;
			cfg_out.ctrl_frames_en <= (mode == SBI_PAR16) || (mode == SBI_PAR8); // [RULE22]
		end
	end

	// only transactions carrying our id are answered
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			serial_select_out <= 1'b0;
		end else begin
			serial_select_out <= serial_mode && serial_id_valid_in &&
				(serial_dev_id_in == strap[6:4]); // [RULE3]
		end
	end

	// ----------------------------------------
	// table init and self test
	// ----------------------------------------
	logic [31:0] init_cnt;
	logic tables_ready;
	logic [8:0] bist_cnt;
	logic bist_req;
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			bist_cnt <= 9'(BIST_CYC); // power-up self test [RULE23]
		end else if (bist_req) begin
			bist_cnt <= 9'(BIST_CYC); // [RULE23]
		end else if (bist_cnt != 9'h000) begin
			bist_cnt <= bist_cnt - 9'h001;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			init_cnt <= 32'h0;
			tables_ready <= 1'b0;
		end else if (!tables_ready) begin
			init_cnt <= init_cnt + 32'h1;
			tables_ready <= (init_cnt >= 32'(TABLE_INIT_CYCLES - 1));
		end
	end

	// ----------------------------------------
	// AHB-Lite slave
	// ----------------------------------------
	logic init_complete;
	logic wr_pend;
	logic [7:0] wr_addr;
	logic take;
	assign take = ahb_req_in.hsel && ahb_req_in.htrans[1] && hready_in;
	assign bist_req = wr_pend && (wr_addr == GCR_OFF) && hwdata_in[GCR_BIST_BIT];

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end else begin
			wr_pend <= take && ahb_req_in.hwrite;
			wr_addr <= ahb_req_in.haddr;
		end
	end

	// early overrides before tables are ready are the host's fault; bit still lands
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			init_complete <= 1'b0;
		end else if (wr_pend && wr_addr == GCR_OFF && hwdata_in[GCR_INIT_BIT]) begin
			init_complete <= 1'b1; // [RULE8] [RULE9]
		end
	end

	function automatic logic [31:0] read_mux(input logic [7:0] a);
		case (a)
			GCR_OFF: read_mux = {27'h0, init_complete, 3'h0, bist_cnt != 9'h000};
			STRAP_OFF: read_mux = {12'h0, mod_type, strap};
			STATUS_OFF: read_mux = {26'h0, stuck_flag_out, tables_ready,
				switch_enable_out, mode};
			DEFAULTS_OFF: read_mux = {3'h0, AGE_TIME_S, CPU_PAD_BYTES, RETRY_LIMIT,
				3'h0, FLOW_QUEUE_DEF}; // [RULE12] [RULE13] [RULE16]
			// uplink fields in units of four buffers so all four fit one word
			BUFPOOL_OFF: read_mux = {UP_POOL_DEF[9:2], UP_FC_DEF[9:2], FE_POOL_DEF[7:0],
				FE_FC_DEF[7:0]}; // [RULE14]
			PHYADDR_OFF: read_mux = {17'h0, PHY_ADDR_UP, PHY_ADDR_P1,
				PHY_ADDR_P0}; // [RULE18] [RULE19]
			default: read_mux = 32'h0;
		endcase
	endfunction

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			hrdata_out <= 32'h0;
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
		end else begin
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
			if (take && !ahb_req_in.hwrite) begin
				hrdata_out <= read_mux(ahb_req_in.haddr);
			end
		end
	end

	// ----------------------------------------
	// switching start
	// ----------------------------------------
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			switch_enable_out <= 1'b0;
			bist_busy_out <= 1'b1;
		end else begin
			bist_busy_out <= (bist_cnt != 9'h000);
			// unmanaged starts once the self test ends; others also wait for host [RULE7] [RULE8]
			switch_enable_out <= straps_taken && (bist_cnt == 9'h000) &&
				(unmanaged || init_complete);
		end
	end

	// ----------------------------------------
	// default frame policy
	// ----------------------------------------
	logic reserved_grp;
	logic len_ok;
	assign reserved_grp = (frame_da_in[47:4] == 44'h0180C20000_0);
	assign len_ok = (frame_len_in >= FRAME_MIN) && (frame_len_in <= FRAME_MAX); // [RULE15]

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			frame_drop_out <= 1'b0;
			frame_to_cpu_out <= 1'b0;
			learn_ok_out <= 1'b0;
		end else begin
			frame_drop_out <= frame_valid_in && (!switch_enable_out || !len_ok ||
				(reserved_grp && frame_da_in[3:0] != 4'h0) || // [RULE10] [RULE11]
				(ctrl_frame_in && unmanaged)); // [RULE22]
			frame_to_cpu_out <= frame_valid_in && switch_enable_out && len_ok &&
				!unmanaged && reserved_grp && frame_da_in[3:0] == 4'h0; // [RULE11]
			learn_ok_out <= frame_valid_in && switch_enable_out &&
				(frame_sa_in != 48'h0); // [RULE10]
		end
	end

	// ----------------------------------------
	// collision retry and uplink duplex check
	// ----------------------------------------
	logic [4:0] attempts;
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			attempts <= 5'h01;
			retry_out <= 1'b0;
			tx_give_up_out <= 1'b0;
		end else begin
			retry_out <= 1'b0;
			tx_give_up_out <= 1'b0;
			if (collision_in) begin
				if (attempts >= RETRY_LIMIT) begin
					tx_give_up_out <= 1'b1; // [RULE17]
					attempts <= 5'h01;
				end else begin
					retry_out <= 1'b1; // [RULE17]
					attempts <= attempts + 5'h01;
				end
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			uplink_mode_err_out <= 1'b0;
		end else begin
			uplink_mode_err_out <= (uplink_speed_in == 2'h2) && !uplink_full_duplex_in; // [RULE21]
		end
	end

	// ----------------------------------------
	// stuck state machine monitor
	// ----------------------------------------
	logic [39:0] stuck_cnt;
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			stuck_cnt <= 40'h0;
			stuck_flag_out <= 1'b0;
		end else if (!cfg_out.timeout_mon_en || fsm_busy_in == 3'h0) begin
			stuck_cnt <= 40'h0;
		end else begin
			stuck_cnt <= stuck_cnt + 40'h1;
			if (stuck_cnt >= 40'(STUCK_CYCLES)) begin
				stuck_flag_out <= 1'b1; // [RULE24]
			end
		end
	end
	// seven-wire mode bit-0 data path lives in the mac; nothing here [RULE20]
endmodule

/* include/sbi_pkg.sv */
// package for the bootstrap and default-configuration loader
// assumes one system clock and an active-low asynchronous reset
package sbi_pkg;
	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] GCR_OFF = 8'h00;
	localparam logic [7:0] STRAP_OFF = 8'h04;
	localparam logic [7:0] STATUS_OFF = 8'h08;
	localparam logic [7:0] DEFAULTS_OFF = 8'h0C;
	localparam logic [7:0] BUFPOOL_OFF = 8'h10;
	localparam logic [7:0] PHYADDR_OFF = 8'h14;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int GCR_INIT_BIT = 4;
	localparam int GCR_BIST_BIT = 0;
	localparam int STRAP_DEBOUNCE = 0;
	localparam int STRAP_EEPROM = 7;
	localparam int STRAP_MODDET = 9;
	localparam int STRAP_TIMEOUT = 12;
	localparam logic [15:0] STRAP_RESET = 16'hFFFF;
	// ----------------------------------------
	// defaults
	// ----------------------------------------
	localparam logic [7:0] FLOW_QUEUE_DEF = 8'h60;
	localparam logic [9:0] FE_POOL_DEF = 10'h060;
	localparam logic [9:0] FE_FC_DEF = 10'h030;
	localparam logic [9:0] UP_POOL_DEF = 10'h180;
	localparam logic [9:0] UP_FC_DEF = 10'h0C0;
	localparam logic [10:0] FRAME_MIN = 11'h040;
	localparam logic [10:0] FRAME_MAX = 11'h5F2;
	localparam logic [4:0] RETRY_LIMIT = 5'h10;
	localparam logic [3:0] CPU_PAD_BYTES = 4'h8;
	localparam logic [4:0] PHY_ADDR_P0 = 5'h08;
	localparam logic [4:0] PHY_ADDR_P1 = 5'h09;
	localparam logic [4:0] PHY_ADDR_UP = 5'h10;
	localparam logic [8:0] AGE_TIME_S = 9'h12C;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_MHZ = 125;
	localparam int TABLE_INIT_US = 100;
	localparam int TABLE_INIT_CYC = TABLE_INIT_US * CLK_MHZ;
	localparam int BIST_CYC = 256;
	localparam int STUCK_S = 5;
	localparam longint STUCK_CYC = longint'(STUCK_S) * 125000000;
	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [2:0] {
		SBI_PAR16, SBI_PAR8, SBI_SER_MII, SBI_SER_LITE, SBI_SER_UNMGD, SBI_BAD
	} sbi_mode_t;
	typedef struct packed {
		logic [1:0] htrans;
		logic hsel;
		logic hwrite;
		logic [2:0] hsize;
		logic [7:0] haddr;
	} sbi_ahb_req_t;
	typedef struct packed {
		logic [2:0] dev_id;
		logic debounce_en;
		logic eeprom_load_en;
		logic module_detect_en;
		logic timeout_mon_en;
		logic managed;
		logic ctrl_frames_en;
	} sbi_cfg_t;
endpackage

/* tb/sbi_top_properties.sv */
// checker on the sbi_top ports
// assumes the bind below and the single system clock
`timescale 1ns/1ps
module sbi_top_properties
	import sbi_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic [47:0] frame_da_in,
	input wire logic [47:0] frame_sa_in,
	input wire logic frame_valid_in,
	input wire logic [10:0] frame_len_in,
	input wire logic [1:0] uplink_speed_in,
	input wire logic uplink_full_duplex_in,
	input wire logic collision_in,
	input wire logic hreadyout_out,
	input wire logic hresp_out,
	input wire sbi_cfg_t cfg_out,
	input wire sbi_mode_t mode_out,
	input wire logic stuck_flag_out,
	input wire logic frame_drop_out,
	input wire logic learn_ok_out,
	input wire logic tx_give_up_out,
	input wire logic uplink_mode_err_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	logic [3:0] ncol;
	logic [1:0] rc;
	wire resv = frame_da_in[47:4] == 44'h0180C200000 && frame_da_in[3:0] != 4'h0;
	// wraps at 16, as the attempt count restarts after a give-up
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) ncol <= 4'h0;
		else if (collision_in) ncol <= ncol + 4'h1;
	end
	// edges since release; cfg settles by the second
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) rc <= 2'h0;
		else if (rc != 2'h3) rc <= rc + 2'h1;
	end
	a_ready_okay: assert property (hreadyout_out && !hresp_out)
		else $error("bus wait or error");
	a_give_up_16: assert property (collision_in && ncol == 4'hF |=> tx_give_up_out)
		else $error("no give-up at 16th attempt");
	a_early_give_up: assert property (tx_give_up_out |-> $past(ncol) == 4'hF)
		else $error("early give-up");
	a_zero_learn: assert property (frame_valid_in && frame_sa_in == 48'h0 |=> !learn_ok_out)
		else $error("zero source learned");
	a_resv_drop: assert property (frame_valid_in && resv |=> frame_drop_out)
		else $error("reserved group kept");
	a_len_drop: assert property (frame_valid_in && (frame_len_in < 11'h040
		|| frame_len_in > 11'h5F2) |=> frame_drop_out) else $error("bad length kept");
	a_eeprom_mode: assert property (cfg_out.eeprom_load_en |-> mode_out == SBI_SER_UNMGD)
		else $error("eeprom outside unmanaged");
	a_strap_hold: assert property (rc == 2'h3 |-> $stable(mode_out) && $stable(cfg_out))
		else $error("straps changed");
	a_stuck_sticky: assert property (stuck_flag_out |=> stuck_flag_out)
		else $error("stuck flag dropped");
	a_uplink_half: assert property (uplink_speed_in == 2'h2 && !uplink_full_duplex_in
		|-> ##[0:1] uplink_mode_err_out) else $error("1G half not flagged");
	c_give_up: cover property (tx_give_up_out);
	c_resv: cover property (frame_valid_in && resv);
	c_stuck: cover property (stuck_flag_out);
endmodule
bind sbi_top sbi_top_properties u_props (.clk_sys_in, .rst_n_in, .frame_da_in, .frame_sa_in,
	.frame_valid_in, .frame_len_in, .uplink_speed_in, .uplink_full_duplex_in, .collision_in,
	.hreadyout_out, .hresp_out, .cfg_out, .mode_out, .stuck_flag_out, .frame_drop_out,
	.learn_ok_out, .tx_give_up_out, .uplink_mode_err_out);

/* tb/sbi_host_model.sv */
// host processor model: single-word AHB-Lite master
// assumes one slave whose hreadyout is the bus hready
`timescale 1ns/1ps
module sbi_host_model
	import sbi_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic hready_in,
	input wire logic [31:0] hrdata_in,
	output sbi_ahb_req_t ahb_req_out = '0,
	output logic [31:0] hwdata_out = 32'h0,
	output logic timed_out = 1'b0
);
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge clk_sys_in);
			n++;
		end while (hready_in !== 1'b1 && n < 64);
		if (hready_in !== 1'b1) timed_out = 1'b1;
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		ahb_req_out <= '{2'b10, 1'b1, w, 3'b010, a};
		wait_rdy();
		// released address lines show a changed value, not the last one
		ahb_req_out <= '{2'b00, 1'b0, 1'b0, 3'b010, ~a};
		hwdata_out <= d;
		wait_rdy();
		q = hrdata_in;
		hwdata_out <= ~d;
	endtask
	// table init time after reset before any register access
	task automatic settle(input int n);
		repeat (n) @(posedge clk_sys_in);
	endtask
endmodule

/* tb/testbench.sv */
// bench for strap decode, defaults and switching start
// assumes the host model owns the register bus
`timescale 1ns/1ps
module testbench;
	import sbi_pkg::*;
	logic clk = 0, rst_n = 0, sidv = 0, fv = 0, cf = 0, fd = 1, col = 0, tmo, rdy, resp;
	logic ssel, swe, bist, stuck, drop, tocpu, learn, retry, gup, uerr;
	logic [15:0] strap = 16'hFFFF;
	logic [3:0] txen = 4'hA;
	logic [2:0] sid = 3'h0, busy = 3'h0;
	logic [47:0] da = 48'h0, sa = 48'h0;
	logic [10:0] len = 11'h040;
	logic [1:0] spd = 2'h0;
	logic [31:0] wd, rd, q;
	sbi_ahb_req_t req;
	sbi_cfg_t cfg;
	sbi_mode_t mode;
	int mismatches = 0, n_tests = 0;
	logic [2:0] code [5] = '{3'h7, 3'h3, 3'h2, 3'h0, 3'h1};
	sbi_mode_t em [5] = '{SBI_SER_UNMGD, SBI_SER_LITE, SBI_SER_MII, SBI_PAR16, SBI_PAR8};
	sbi_top #(.TABLE_INIT_CYCLES(10), .STUCK_CYCLES(20)) DUT (.clk_sys_in(clk),
		.rst_n_in(rst_n), .strap_inputs_in(strap), .port_tx_enable_strap_in(txen),
		.serial_dev_id_in(sid), .serial_id_valid_in(sidv), .fsm_busy_in(busy),
		.frame_da_in(da), .frame_sa_in(sa), .frame_valid_in(fv), .ctrl_frame_in(cf),
		.frame_len_in(len), .uplink_speed_in(spd), .uplink_full_duplex_in(fd),
		.collision_in(col), .ahb_req_in(req), .hready_in(rdy), .hwdata_in(wd),
		.hrdata_out(rd), .hreadyout_out(rdy), .hresp_out(resp), .cfg_out(cfg),
		.mode_out(mode), .serial_select_out(ssel), .switch_enable_out(swe),
		.bist_busy_out(bist), .stuck_flag_out(stuck), .frame_drop_out(drop),
		.frame_to_cpu_out(tocpu), .learn_ok_out(learn), .retry_out(retry),
		.tx_give_up_out(gup), .uplink_mode_err_out(uerr));
	sbi_host_model host (.clk_sys_in(clk), .hready_in(rdy), .hrdata_in(rd),
		.ahb_req_out(req), .hwdata_out(wd), .timed_out(tmo));
	initial forever #4 clk = ~clk;
	task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge tmo) begin
		mismatches++;
		report_and_stop();
	end
	task automatic boot(input logic [15:0] s);
		@(posedge clk);
		rst_n <= 1'b0;
		strap <= s;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
	endtask
	// frame result pulses land one cycle after the valid cycle
	task automatic frm(input logic [47:0] d, input logic [10:0] l, input logic c);
		@(posedge clk);
		da <= d;
		sa <= 48'h020000000001;
		len <= l;
		cf <= c;
		fv <= 1'b1;
		@(posedge clk);
		fv <= 1'b0;
		#1;
	endtask
	task automatic sel(input logic [2:0] v, input logic e);
		@(posedge clk);
		sid <= v;
		sidv <= 1'b1;
		@(posedge clk);
		#1;
		chk("select", e, ssel);
		sidv <= 1'b0;
	endtask
	task automatic wait_sw();
		for (int n = 0; n < 600 && swe !== 1'b1; n++) @(posedge clk);
		chk("switch_on", 1'b1, swe);
		if (swe !== 1'b1) report_and_stop();
	endtask
	initial begin
		for (int i = 0; i < 5; i++) begin
			logic [2:0] v;
			v = 3'(i);
			boot({6'b111010, v[1], 2'b10, v, code[i], v[0]});
			chk("mode", em[i], mode);
			chk("eeprom", i == 0, cfg.eeprom_load_en);
			chk("moddet", v[1], cfg.module_detect_en);
			chk("bist", 1'b1, bist);
			if (i < 3) begin
				chk("id", v, cfg.dev_id);
				chk("debounce", v[0], cfg.debounce_en);
				sel(v, 1'b1);
				sel(v + 3'h1, 1'b0);
			end
		end
		strap <= 16'h0000;
		$display("test strap modes done");
		boot(16'hF90E);
		wait_sw();
		frm(48'h0180C2000005, 11'h040, 1'b0);
		chk("resv_drop", 1'b1, drop);
		chk("learn", 1'b1, learn);
		frm(48'h020000000009, 11'h5F2, 1'b0);
		chk("max_len", 1'b0, drop);
		frm(48'h020000000009, 11'h5F3, 1'b0);
		chk("long_len", 1'b1, drop);
		frm(48'h020000000009, 11'h040, 1'b1);
		chk("ctrl_unmgd", 1'b1, drop);
		busy <= 3'h1;
		repeat (30) @(posedge clk);
		#1;
		chk("stuck", 1'b1, stuck);
		busy <= 3'h0;
		for (int k = 1; k <= 16; k++) begin
			@(posedge clk);
			col <= 1'b1;
			@(posedge clk);
			col <= 1'b0;
			#1;
			chk("give_up", k == 16, gup);
			chk("retry", k != 16, retry);
		end
		spd <= 2'h2;
		fd <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk("uplink_half", 1'b1, uerr);
		fd <= 1'b1;
		$display("test unmanaged done");
		boot(16'hE9F1);
		host.settle(10);
		repeat (300) @(posedge clk);
		chk("no_start", 1'b0, swe);
		host.xfer(1'b0, 8'h40, 32'h0, q);
		chk("unmapped", 32'h0, q);
		host.xfer(1'b0, DEFAULTS_OFF, 32'h0, q);
		chk("defaults", 32'h12C88060, q);
		host.xfer(1'b0, BUFPOOL_OFF, 32'h0, q);
		chk("bufpool", 32'h60306030, q);
		host.xfer(1'b0, PHYADDR_OFF, 32'h0, q);
		chk("phyaddr", 32'h00004128, q);
		host.xfer(1'b1, GCR_OFF, 32'h10, q);
		wait_sw();
		frm(48'h0180C2000000, 11'h040, 1'b0);
		chk("to_cpu", 1'b1, tocpu);
		frm(48'h0180C200000F, 11'h040, 1'b0);
		chk("resv_cpu", 1'b0, tocpu);
		host.xfer(1'b1, GCR_OFF, 32'h11, q);
		@(posedge clk);
		#1;
		chk("bist_req", 1'b1, bist);
		$display("test managed done");
		report_and_stop();
	end
endmodule
